// ===== hw/radio_interrupt_wake_logic.sv
// interrupt collection, request pin and crystal wake control
`timescale 1ns/1ps
`default_nettype none
`include "radio_irq_defs.svh"
module radio_interrupt_wake_logic
	import radio_irq_pkg::*;
#(
	parameter int WAKE_CYCLES = `WAKE_CYC
)
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       txRegEnable,
	input  wire logic       transmitterEnable,
	input  wire logic       rxFifoEnable,
	input  wire logic       receiverEnable,
	input  wire logic       wakeTimerEnable,
	input  wire logic       extPinSelect,
	input  wire logic       lowSupplyEnable,
	input  wire logic [3:0] lowSupplyThreshold,
	input  wire logic [3:0] fifoFillLevel,
	input  wire logic       xtalEnable,
	input  wire logic       clockOutEnable,
	input  wire logic       txByteWrite,
	input  wire logic       bitRateByteDone,
	input  wire logic       rxBitIn,
	input  wire logic       rxBitRead,
	input  wire logic       statusRead,
	input  wire logic       validData,
	input  wire logic [3:0] supplyLevel,
	input  wire logic       extIntN,
	output logic            irqOutN,
	output logic            txReadyRxFillFlag,
	output logic            underrunOverflowFlag,
	output logic            wakeTimerEvent,
	output logic            extPinEvent,
	output logic            lowSupplyEvent,
	output logic            powerOnFlag,
	output logic            xtalRunning,
	output logic            clockOutRun,
	output logic            sleeping,
	output logic            wakeReceive
);

	logic                     txEmpty_r;
	logic                     txReady_r;
	logic                     underrun_r;
	logic [`FIFO_CNT_W-1:0]   fill_r;
	logic [`FIFO_CNT_W-1:0]   readCnt_r;
	logic                     fillFlag_r;
	logic                     overflow_r;
	logic [`WAKE_CNT_W-1:0]   wakeCnt_r;
	logic                     wakeFlag_r;
	wake_state_type           wakeState_r;
	logic                     extMeta_r;
	logic                     extSync_r;
	logic                     extFlag_r;
	logic                     lowNow_r;
	logic                     lowReq_r;
	logic                     por_r;
	logic [`TAIL_CNT_W-1:0]   tail_r;
	logic                     irqOutN_r;
	logic                     xtal_r;
	logic                     clkOut_r;
	logic                     sleep_r;
	logic                     readyFillOut_r;
	logic                     uoOut_r;
	logic                     wakeRxOut_r;
	logic                     txMode;
	logic                     rxMode;
	logic                     txOff;
	logic                     rxOff;
	logic                     rxLoad;
	logic                     fillHit;
	logic                     overflowHit;
	logic                     wakeExpire;
	logic                     drainDone;
	logic                     lowCmp;
	logic                     pending;
	logic                     tailBusy;

	// mode decode shared by the transmit and receive sources
	assign txMode   = txRegEnable & transmitterEnable;
	assign rxMode   = rxFifoEnable & receiverEnable;
	assign txOff    = ~transmitterEnable & ~txRegEnable;
	assign rxOff    = ~receiverEnable | ~rxFifoEnable;
	assign rxLoad   = rxMode | (wakeState_r != WAKE_IDLE);
	assign overflowHit = rxLoad & rxBitIn & (fill_r == 5'(`FIFO_BITS));
	assign fillHit  = rxLoad & rxBitIn & ~overflowHit & (fifoFillLevel != 4'h0)
		& ((fill_r + 5'h01) == {1'b0, fifoFillLevel});
	assign wakeExpire = wakeTimerEnable & (wakeCnt_r == `WAKE_CNT_W'(WAKE_CYCLES - 1));
	assign lowCmp   = lowSupplyEnable & (supplyLevel < lowSupplyThreshold);
	assign pending  = txReady_r | underrun_r | fillFlag_r | overflow_r | wakeFlag_r
		| extFlag_r | lowReq_r | por_r;
	assign tailBusy = tail_r != `TAIL_CNT_W'(0);
	assign drainDone = (wakeState_r == WAKE_DRAIN) & (fill_r == 5'h00) & ~validData;

	// transmit holding register: empties when the bit generator takes the byte
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			txEmpty_r <= 1'b1;
		else if (txByteWrite)
			txEmpty_r <= 1'b0;
		else if (bitRateByteDone)
			txEmpty_r <= 1'b1;
	end

	// tx ready: set by emptying or underrun, the write clears; set beats clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			txReady_r <= 1'b0;
		else if (txMode & bitRateByteDone)
			txReady_r <= 1'b1;
		else if (txByteWrite | txOff)
			txReady_r <= 1'b0;
	end

	// underrun: byte finished while nothing new held; only switching off clears it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			underrun_r <= 1'b0;
		else if (txMode & bitRateByteDone & txEmpty_r & ~txByteWrite)
			underrun_r <= 1'b1;
		else if (txOff)
			underrun_r <= 1'b0;
	end

	// receive fill level; saturates at capacity, extra bits are lost
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fill_r <= 5'h00;
		else if (rxOff & (wakeState_r == WAKE_IDLE))
			fill_r <= 5'h00;
		else if (rxLoad & rxBitIn & ~overflowHit & ~(rxBitRead & (fill_r != 5'h00)))
			fill_r <= fill_r + 5'h01;
		else if (rxBitRead & (fill_r != 5'h00) & ~(rxLoad & rxBitIn & ~overflowHit))
			fill_r <= fill_r - 5'h01;
	end

	// bits read since the fill flag rose; reaching the threshold clears the flag
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			readCnt_r <= 5'h00;
		else if (fillHit | ~fillFlag_r)
			readCnt_r <= 5'h00;
		else if (rxBitRead)
			readCnt_r <= readCnt_r + 5'h01;
	end

	// fill flag: held until threshold bits read, wake drain done or receive path switched off
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fillFlag_r <= 1'b0;
		else if (fillHit | overflowHit)
			fillFlag_r <= 1'b1;
		else if (drainDone)
			fillFlag_r <= 1'b0;
		else if ((rxOff & (wakeState_r == WAKE_IDLE))
			| (rxBitRead & ((readCnt_r + 5'h01) >= {1'b0, fifoFillLevel})))
			fillFlag_r <= 1'b0;
	end

	// overflow: set with the fill flag, a status read clears it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow_r <= 1'b0;
		else if (overflowHit)
			overflow_r <= 1'b1;
		else if (statusRead | drainDone | (rxOff & (wakeState_r == WAKE_IDLE)))
			overflow_r <= 1'b0;
	end

	// wake interval counter, free while the timer is enabled
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			wakeCnt_r <= `WAKE_CNT_W'(0);
		else if (!wakeTimerEnable | wakeExpire)
			wakeCnt_r <= `WAKE_CNT_W'(0);
		else
			wakeCnt_r <= wakeCnt_r + `WAKE_CNT_W'(1);
	end

	// wake timer flag; expiry beats a status read in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			wakeFlag_r <= 1'b0;
		else if (wakeExpire)
			wakeFlag_r <= 1'b1;
		else if (statusRead | drainDone)
			wakeFlag_r <= 1'b0;
	end

	// periodic wake reception: listen, drain once valid data shows, idle when data ends and FIFO is empty
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			wakeState_r <= WAKE_IDLE;
		else
		begin
			case (wakeState_r)
				WAKE_IDLE:
					if (wakeExpire)
						wakeState_r <= WAKE_LISTEN;
				WAKE_LISTEN:
					if (validData)
						wakeState_r <= WAKE_DRAIN;
					else if (!wakeFlag_r)
						wakeState_r <= WAKE_IDLE;
				WAKE_DRAIN:
					if (drainDone)
						wakeState_r <= WAKE_IDLE;
				default:
					wakeState_r <= WAKE_IDLE;
			endcase
		end
	end

	// external pin crosses in through two flops before anything reads it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			extMeta_r <= 1'b1;
			extSync_r <= 1'b1;
		end
		else
		begin
			extMeta_r <= extIntN;
			extSync_r <= extMeta_r;
		end
	end

	// external status follows the pin level, no latching
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			extFlag_r <= 1'b0;
		else
			extFlag_r <= ~extPinSelect & ~extSync_r;
	end

	// low supply: status follows level, request latches its rising edge
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lowNow_r <= 1'b0;
			lowReq_r <= 1'b0;
		end
		else
		begin
			lowNow_r <= lowCmp;
			if (lowCmp & ~lowNow_r)
				lowReq_r <= 1'b1;
			else if (statusRead | ~lowCmp)
				lowReq_r <= 1'b0;
		end
	end

	// power-on flag starts set, a status read clears it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			por_r <= 1'b1;
		else if (statusRead)
			por_r <= 1'b0;
	end

	// clock tail: reload while pending, count down once all is quiet
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tail_r <= `TAIL_CNT_W'(0);
		else if (pending)
			tail_r <= `TAIL_CNT_W'(`TAIL_CYC);
		else if (tailBusy)
			tail_r <= tail_r - `TAIL_CNT_W'(1);
	end

	// request pin and crystal; pending sources override the enable bit
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqOutN_r <= 1'b1;
			xtal_r    <= 1'b1;
			clkOut_r  <= 1'b1;
			sleep_r   <= 1'b0;
		end
		else
		begin
			irqOutN_r <= ~pending;
			xtal_r    <= pending | tailBusy | xtalEnable
				| receiverEnable | transmitterEnable;
			clkOut_r  <= pending | tailBusy | (clockOutEnable & xtalEnable);
			sleep_r   <= ~(pending | tailBusy | xtalEnable
				| receiverEnable | transmitterEnable);
		end
	end

	// shared status bits get their own flop so no gate sits on the pin
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			readyFillOut_r <= 1'b0;
			uoOut_r        <= 1'b0;
			wakeRxOut_r    <= 1'b0;
		end
		else
		begin
			readyFillOut_r <= txReady_r | fillFlag_r;
			uoOut_r        <= underrun_r | overflow_r;
			wakeRxOut_r    <= wakeState_r != WAKE_IDLE;
		end
	end

	// outputs straight from flops
	assign irqOutN              = irqOutN_r;
	assign txReadyRxFillFlag    = readyFillOut_r;
	assign underrunOverflowFlag = uoOut_r;
	assign wakeTimerEvent       = wakeFlag_r;
	assign extPinEvent          = extFlag_r;
	assign lowSupplyEvent       = lowNow_r;
	assign powerOnFlag          = por_r;
	assign xtalRunning          = xtal_r;
	assign clockOutRun          = clkOut_r;
	assign sleeping             = sleep_r;
	assign wakeReceive          = wakeRxOut_r;

	// checks on the design's own behaviour
	irq_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pending |=> !irqOutN) else $error("request not low while pending");
	irq_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!pending |=> irqOutN) else $error("request low with nothing pending");
	por_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		statusRead |=> !powerOnFlag) else $error("power-on flag survived read");
	wake_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wakeExpire |=> wakeTimerEvent && (wakeState_r != WAKE_IDLE))
		else $error("expiry missed");
	no_sleep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pending |=> !sleeping && xtalRunning) else $error("slept while pending");
	ovf_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		overflowHit |=> overflow_r && fillFlag_r)
		else $error("overflow not paired with fill");
	udr_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(underrun_r) |-> txReady_r) else $error("underrun without ready");
	ext_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!extPinSelect && !extSync_r) |=> extPinEvent) else $error("ext status lag");
	tail_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(pending) |=> clockOutRun [*8]) else $error("clock tail cut short");
	tx_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(txReady_r && !txByteWrite && !txOff) |=> txReady_r)
		else $error("tx ready dropped early");

endmodule
`default_nettype wire

// ===== hw/radio_irq_defs.svh
// constants for the radio interrupt and wake logic
// Functional notes
// - underrun when byte done before new write
// - overflow when bits exceed sixteen-bit FIFO
// - wake timer event on interval elapse, enabled
// - timer expiry wakes into receive, loads FIFO
// - external status follows low pin level
// - low supply event below selected threshold
// - any source drives request low, sets status
// - tx ready held until write or off
// - fill flag held until threshold bits read
// - power-on flag cleared by status read
// - underrun set with ready, held until off
// - overflow set with fill, cleared on read
// - wake timer flag cleared by status read
// - low supply request cleared, status follows level
// - any source wakes and starts crystal clock
// - no sleep while any interrupt pending
// - enable bit alone governs crystal when idle; here receiverEnable or transmitterEnable also keep it running
// - clock tail after activity before stopping
// - wake reception drained then clear, sleep
// - tx ready event when register empties
// - fill event when count reaches threshold
`ifndef RADIO_IRQ_DEFS_SVH
`define RADIO_IRQ_DEFS_SVH

`define CLK_MHZ        125
`define FIFO_BITS      16
`define FIFO_CNT_W     5
`define WAKE_US        1000
`define WAKE_CYC       (`WAKE_US * `CLK_MHZ)
`define TAIL_NS        2048
`define TAIL_CYC       ((`TAIL_NS * `CLK_MHZ) / 1000)
`define TAIL_CNT_W     9
`define WAKE_CNT_W     24

`endif

// ===== hw/radio_irq_pkg.sv
// types for the radio interrupt and wake logic
package radio_irq_pkg;
	typedef enum logic [1:0]
	{
		WAKE_IDLE   = 2'b00,
		WAKE_LISTEN = 2'b01,
		WAKE_DRAIN  = 2'b10
	} wake_state_type;
endpackage

// ===== tb/host_model.sv
// host side model that reads the status word on request
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic irqOutN,
	input  wire logic autoAck,
	input  wire logic readReq,
	output logic      statusRead
);
	logic [2:0] waitCnt;

	// one-cycle status read; random pause makes the host prompt or slow
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			statusRead <= 1'b0;
			waitCnt    <= 3'h0;
		end
		else if (readReq)
			statusRead <= 1'b1;
		else if (statusRead)
		begin
			statusRead <= 1'b0;
			waitCnt    <= 3'h4; // request pin lags the flags, so wait before looking again
		end
		else if (waitCnt != 3'h0)
			waitCnt <= waitCnt - 3'h1;
		else if (autoAck && !irqOutN && $urandom_range(1, 0) == 0)
			statusRead <= 1'b1;
	end
endmodule
`default_nettype wire

// ===== tb/radio_interrupt_wake_logic_test.sv
// self-checking bench for the interrupt and wake logic
`timescale 1ns/1ps
`default_nettype none
module radio_interrupt_wake_logic_test;
	import radio_irq_pkg::*;
	typedef struct {int id; logic v;} note_type;
	note_type expQ[$];
	int errors = 0;
	int n_compared = 0;
	int lvl;
	string nm[11] = '{"irqOutN", "fillFlag", "uoFlag", "wakeEv", "extEv", "lowEv",
		"porFlag", "xtal", "sleeping", "wakeRx", "clkOut"};
	logic ref_clk = 0, rst_n = 0, chk = 0, autoAck = 0, readReq = 0;
	logic txRegEnable = 0, transmitterEnable = 0, rxFifoEnable = 0, receiverEnable = 0;
	logic wakeTimerEnable = 0, extPinSelect = 0, lowSupplyEnable = 0;
	logic xtalEnable = 1, clockOutEnable = 1, validData = 0, extIntN = 1;
	logic txByteWrite = 0, bitRateByteDone = 0, rxBitIn = 0, rxBitRead = 0;
	logic [3:0] lowSupplyThreshold = 4'h0, fifoFillLevel = 4'h0, supplyLevel = 4'hf;
	wire logic statusRead, irqOutN, txReadyRxFillFlag, underrunOverflowFlag, wakeTimerEvent;
	wire logic extPinEvent, lowSupplyEvent, powerOnFlag, xtalRunning, clockOutRun;
	wire logic sleeping, wakeReceive;
	wire logic [10:0] seen = {clockOutRun, wakeReceive, sleeping, xtalRunning, powerOnFlag,
		lowSupplyEvent, extPinEvent, wakeTimerEvent, underrunOverflowFlag,
		txReadyRxFillFlag, irqOutN};

	always #4 ref_clk = ~ref_clk;

	radio_interrupt_wake_logic #(.WAKE_CYCLES(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.txRegEnable(txRegEnable), .transmitterEnable(transmitterEnable),
		.rxFifoEnable(rxFifoEnable), .receiverEnable(receiverEnable),
		.wakeTimerEnable(wakeTimerEnable), .extPinSelect(extPinSelect),
		.lowSupplyEnable(lowSupplyEnable), .lowSupplyThreshold(lowSupplyThreshold),
		.fifoFillLevel(fifoFillLevel), .xtalEnable(xtalEnable),
		.clockOutEnable(clockOutEnable), .txByteWrite(txByteWrite),
		.bitRateByteDone(bitRateByteDone), .rxBitIn(rxBitIn), .rxBitRead(rxBitRead),
		.statusRead(statusRead), .validData(validData), .supplyLevel(supplyLevel),
		.extIntN(extIntN), .irqOutN(irqOutN), .txReadyRxFillFlag(txReadyRxFillFlag),
		.underrunOverflowFlag(underrunOverflowFlag), .wakeTimerEvent(wakeTimerEvent),
		.extPinEvent(extPinEvent), .lowSupplyEvent(lowSupplyEvent),
		.powerOnFlag(powerOnFlag), .xtalRunning(xtalRunning), .clockOutRun(clockOutRun),
		.sleeping(sleeping), .wakeReceive(wakeReceive));

	host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .irqOutN(irqOutN),
		.autoAck(autoAck), .readReq(readReq), .statusRead(statusRead));

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// one-cycle strobe, then a free edge so the next strobe never collides
	task automatic pulse(input int w);
		case (w)
			0: bitRateByteDone <= 1'b1;
			1: txByteWrite <= 1'b1;
			2: rxBitIn <= 1'b1;
			3: rxBitRead <= 1'b1;
			default: readReq <= 1'b1;
		endcase
		tick(1);
		{bitRateByteDone, txByteWrite, rxBitIn, rxBitRead, readReq} <= 5'h00;
		tick(1);
	endtask

	// note the expectation; the watcher compares it at the next falling edge
	task automatic expect_val(input int id, input logic v);
		expQ.push_back('{id, v});
		chk <= 1'b1;
		tick(1);
		chk <= 1'b0;
	endtask

	always @(negedge ref_clk)
		if (chk)
		begin
			n_compared++;
			if (seen[expQ[0].id] !== expQ[0].v)
			begin
				errors++;
				$display("[ERR] %s expected %b seen %b", nm[expQ[0].id], expQ[0].v,
					seen[expQ[0].id]);
			end
			void'(expQ.pop_front());
		end

	task automatic end_of_test;
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog sized well beyond the roughly 850 cycles the sequence needs
	initial
	begin
		tick(20000);
		errors++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(54));
		tick(4);
		expect_val(6, 1'b1);
		expect_val(0, 1'b1);
		rst_n <= 1'b1;
		autoAck <= 1'b1;
		tick(16);
		expect_val(6, 1'b0);
		expect_val(0, 1'b1);
		autoAck <= 1'b0;
		// sleep entry, clock tail and wake by the external pin
		xtalEnable <= 1'b0;
		tick(100);
		expect_val(10, 1'b1);
		tick(200);
		expect_val(7, 1'b0);
		expect_val(8, 1'b1);
		extIntN <= 1'b0;
		tick(4);
		expect_val(4, 1'b1);
		expect_val(0, 1'b0);
		expect_val(7, 1'b1);
		tick(300);
		expect_val(8, 1'b0);
		extPinSelect <= 1'b1;
		tick(2);
		expect_val(4, 1'b0);
		extPinSelect <= 1'b0;
		extIntN <= 1'b1;
		tick(5);
		expect_val(4, 1'b0);
		xtalEnable <= 1'b1;
		tick(3);
		expect_val(7, 1'b1);
		// transmit: refused, then underrun with ready, cleared in turn
		txRegEnable <= 1'b1;
		pulse(0);
		tick(2);
		expect_val(2, 1'b0);
		transmitterEnable <= 1'b1;
		pulse(0);
		expect_val(1, 1'b1);
		expect_val(2, 1'b1);
		pulse(1);
		tick(2);
		expect_val(1, 1'b0);
		expect_val(0, 1'b0);
		{txRegEnable, transmitterEnable} <= 2'b00;
		tick(4);
		expect_val(2, 1'b0);
		expect_val(0, 1'b1);
		// receive: threshold, overflow on the seventeenth bit, clears
		lvl = $urandom_range(15, 2);
		fifoFillLevel <= 4'(lvl);
		{rxFifoEnable, receiverEnable} <= 2'b11;
		repeat (lvl - 1) pulse(2);
		tick(2);
		expect_val(1, 1'b0);
		pulse(2);
		tick(2);
		expect_val(1, 1'b1);
		expect_val(0, 1'b0);
		repeat (17 - lvl) pulse(2);
		tick(2);
		expect_val(2, 1'b1);
		pulse(4);
		tick(2);
		expect_val(2, 1'b0);
		expect_val(1, 1'b1);
		repeat (lvl) pulse(3);
		tick(2);
		expect_val(1, 1'b0);
		{rxFifoEnable, receiverEnable} <= 2'b00;
		// wake timer expiry and periodic reception
		wakeTimerEnable <= 1'b1;
		tick(26);
		expect_val(3, 1'b1);
		expect_val(9, 1'b1);
		wakeTimerEnable <= 1'b0;
		pulse(4);
		tick(2);
		expect_val(3, 1'b0);
		expect_val(9, 1'b0);
		// wake reception with valid data: drain empties, flags clear with no read
		wakeTimerEnable <= 1'b1;
		fifoFillLevel <= 4'h1;
		tick(22);
		validData <= 1'b1;
		wakeTimerEnable <= 1'b0;
		tick(2);
		pulse(2);
		tick(2);
		expect_val(1, 1'b1);
		expect_val(0, 1'b0);
		validData <= 1'b0;
		pulse(3);
		tick(3);
		expect_val(3, 1'b0);
		expect_val(9, 1'b0);
		expect_val(1, 1'b0);
		// low supply: request released by a read, status follows the level
		lvl = $urandom_range(15, 4);
		lowSupplyThreshold <= 4'(lvl);
		supplyLevel <= 4'(lvl - 1);
		lowSupplyEnable <= 1'b1;
		tick(4);
		expect_val(5, 1'b1);
		expect_val(0, 1'b0);
		pulse(4);
		tick(3);
		expect_val(0, 1'b1);
		expect_val(5, 1'b1);
		supplyLevel <= 4'(lvl);
		tick(3);
		expect_val(5, 1'b0);
		tick(2);
		end_of_test();
	end
endmodule
`default_nettype wire
